// >>> design/t2ac_pkg.sv
// constants for the timer2 async update, irq and prescaler control block
package t2ac_pkg;
  localparam int ADDR_W = 12;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_COUNTER = 8'h40;
  localparam logic [7:0] IDX_CMP_A   = 8'h41;
  localparam logic [7:0] IDX_CMP_B   = 8'h42;
  localparam logic [7:0] IDX_GENERAL = 8'h43;
  localparam logic [7:0] IDX_CTRL_A  = 8'h44;
  localparam logic [7:0] IDX_CTRL_B  = 8'h45;
  localparam logic [7:0] IDX_ASYNC   = 8'h46;
  localparam logic [7:0] IDX_MASK    = 8'h47;
  localparam logic [7:0] IDX_FLAGS   = 8'h48;
  // staging entries, numbered as their busy bits in the async status
  localparam int ENT_CTRL_B  = 0;
  localparam int ENT_CTRL_A  = 1;
  localparam int ENT_CMP_B   = 2;
  localparam int ENT_CMP_A   = 3;
  localparam int ENT_COUNTER = 4;
  localparam int ENTRIES     = 5;
  localparam int BIT_ASYNC_SEL = 5;
  // general control fields
  localparam int BIT_SYNC_MODE  = 7;
  localparam int BIT_ASYNC_PRST = 1;
  localparam int BIT_SHARED_PRST = 0;
  // interrupt flag and mask bits
  localparam int BIT_OVF   = 0;
  localparam int BIT_CMP_A = 1;
  localparam int BIT_CMP_B = 2;
  localparam int IRQ_BITS  = 3;
  // control field, reset values, counter limits and prescaler width
  localparam int BIT_WGM2 = 3;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] COUNT_MAX  = 8'hff;
  localparam logic [7:0] COUNT_BOT  = 8'h00;
  localparam logic [9:0] PRESC_RST  = 10'h000;
  localparam int PRESC_W = 10;
endpackage

// >>> design/t2ac_timer.sv
// timer2 register side: staging, busy flags, irq flags, prescaler resets
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
module t2ac_timer #(
  parameter int ADDR_W = t2ac_pkg::ADDR_W
) (
  input  wire logic              pclk,              // bus clock, 40 MHz
  input  wire logic              presetn,           // async reset, low
  input  wire logic              psel,              // apb select
  input  wire logic              penable,           // apb enable
  input  wire logic              pwrite,            // apb direction
  input  wire logic [ADDR_W-1:0] paddr,             // apb byte address
  input  wire logic [31:0]       pwdata,            // apb write data
  output logic      [31:0]       prdata,            // apb read data
  output logic                   pready,            // apb ready
  output logic                   pslverr,           // apb error
  input  wire logic              tosc_in,           // oscillator pin
  input  wire logic              global_irq_enable, // cpu i-bit
  input  wire logic [2:0]        vector_ack,        // vector taken pulse
  output logic [2:0]             irq_req,           // per event request
  output logic                   irq,               // any unmasked flag
  output logic                   shared_prescaler_reset // other timers
);
  logic [7:0] stage [t2ac_pkg::ENTRIES];
  logic [7:0] live  [t2ac_pkg::ENTRIES];
  logic [t2ac_pkg::ENTRIES-1:0] busy;
  logic [t2ac_pkg::ENTRIES-1:0] wr_sel;
  logic       async_clock_select;
  logic       sync_mode_hold;
  logic       async_prescaler_reset;
  logic [2:0] timer2_interrupt_mask;
  logic [2:0] timer2_interrupt_flags;
  logic       tosc_s1;
  logic       tosc_s2;
  logic       tosc_s3;
  logic       timer_tick;
  logic [t2ac_pkg::PRESC_W-1:0] presc;
  logic [t2ac_pkg::PRESC_W-1:0] div_mask;
  logic       count_en;
  logic       count_down;
  logic [7:0] top;
  logic [2:0] wgm;
  logic       phase_correct;
  logic       ev_ovf;
  logic       ev_cmp_a;
  logic       ev_cmp_b;
  logic [2:0] events;
  logic       setup;
  logic       access;
  logic       wr;
  logic [7:0] idx;
  logic       mapped;
  logic [7:0] rd_byte;

  // ---------------- apb slave ----------------
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wr     = access && pwrite && mapped;
  assign idx    = paddr[9:2];
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;

  // only the nine register words answer; anything else is an error
  always_comb begin
    mapped = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
    case (idx)
      t2ac_pkg::IDX_COUNTER, t2ac_pkg::IDX_CMP_A, t2ac_pkg::IDX_CMP_B,
      t2ac_pkg::IDX_GENERAL, t2ac_pkg::IDX_CTRL_A, t2ac_pkg::IDX_CTRL_B,
      t2ac_pkg::IDX_ASYNC, t2ac_pkg::IDX_MASK, t2ac_pkg::IDX_FLAGS: begin
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  assign pslverr = access && !mapped;

  // unused bits of every register read as zero
  always_comb begin
    rd_byte = t2ac_pkg::RST_BYTE;
    case (idx)
      t2ac_pkg::IDX_COUNTER: rd_byte = live[t2ac_pkg::ENT_COUNTER];
      t2ac_pkg::IDX_CMP_A:   rd_byte = stage[t2ac_pkg::ENT_CMP_A];
      t2ac_pkg::IDX_CMP_B:   rd_byte = stage[t2ac_pkg::ENT_CMP_B];
      t2ac_pkg::IDX_CTRL_A:  rd_byte = stage[t2ac_pkg::ENT_CTRL_A];
      t2ac_pkg::IDX_CTRL_B:  rd_byte = stage[t2ac_pkg::ENT_CTRL_B];
      t2ac_pkg::IDX_GENERAL: begin
        rd_byte[t2ac_pkg::BIT_SYNC_MODE]   = sync_mode_hold;
        rd_byte[t2ac_pkg::BIT_ASYNC_PRST]  = async_prescaler_reset;
        rd_byte[t2ac_pkg::BIT_SHARED_PRST] = shared_prescaler_reset;
      end
      t2ac_pkg::IDX_ASYNC: begin
        rd_byte[t2ac_pkg::ENTRIES-1:0] = busy;
        rd_byte[t2ac_pkg::BIT_ASYNC_SEL] = async_clock_select;
      end
      t2ac_pkg::IDX_MASK:  rd_byte[2:0] = timer2_interrupt_mask;
      t2ac_pkg::IDX_FLAGS: rd_byte[2:0] = timer2_interrupt_flags;
      default: rd_byte = t2ac_pkg::RST_BYTE;
    endcase
  end

  // read data captured in the setup phase so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // ---------------- timer clock source ----------------
  // oscillator pin is outside our domain; only s2 and s3 feed logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tosc_s1 <= 1'b0;
      tosc_s2 <= 1'b0;
      tosc_s3 <= 1'b0;
    end else begin
      tosc_s1 <= tosc_in;
      tosc_s2 <= tosc_s1;
      tosc_s3 <= tosc_s2;
    end
  end

  // oscillator edges when async, every bus clock otherwise
  assign timer_tick = async_clock_select ? (tosc_s2 && !tosc_s3)
                                         : 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async_clock_select <= 1'b0;
    end else if (wr && idx == t2ac_pkg::IDX_ASYNC) begin
      // switching source mid-count may leave staged values stale
      async_clock_select <= pwdata[t2ac_pkg::BIT_ASYNC_SEL];
    end
  end

  // ---------------- staging and busy flags ----------------
  always_comb begin
    // one-hot select of the staged register being written
    wr_sel = '0;
    if (wr) begin
      case (idx)
        t2ac_pkg::IDX_CTRL_B:  wr_sel[t2ac_pkg::ENT_CTRL_B]  = 1'b1;
        t2ac_pkg::IDX_CTRL_A:  wr_sel[t2ac_pkg::ENT_CTRL_A]  = 1'b1;
        t2ac_pkg::IDX_CMP_B:   wr_sel[t2ac_pkg::ENT_CMP_B]   = 1'b1;
        t2ac_pkg::IDX_CMP_A:   wr_sel[t2ac_pkg::ENT_CMP_A]   = 1'b1;
        t2ac_pkg::IDX_COUNTER: wr_sel[t2ac_pkg::ENT_COUNTER] = 1'b1;
        default: wr_sel = '0;
      endcase
    end
  end

  // a write racing its own transfer keeps busy: new value goes next tick
  for (genvar e = 0; e < t2ac_pkg::ENTRIES; e++) begin : g_stage
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stage[e] <= t2ac_pkg::RST_BYTE;
        busy[e]  <= 1'b0;
      end else begin
        if (wr_sel[e]) begin
          stage[e] <= pwdata[7:0];
        end
        // busy only in async mode; sync writes land at once
        if (wr_sel[e] && async_clock_select) begin
          busy[e] <= 1'b1;
        end else if (timer_tick) begin
          busy[e] <= 1'b0;
        end
      end
    end
  end

  // compare and control live copies; the counter has its own process
  for (genvar e = 0; e < t2ac_pkg::ENT_COUNTER; e++) begin : g_live
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        live[e] <= t2ac_pkg::RST_BYTE;
      end else if (wr_sel[e] && !async_clock_select) begin
        live[e] <= pwdata[7:0];
      end else if (busy[e] && timer_tick && !wr_sel[e]) begin
        live[e] <= stage[e];
      end
    end
  end

  // ---------------- prescaler ----------------
  always_comb begin
    // prescaler taps for /8 up to /1024; /1 needs no tap
    case (live[t2ac_pkg::ENT_CTRL_B][2:0])
      3'd2:    div_mask = 10'h007;
      3'd3:    div_mask = 10'h01f;
      3'd4:    div_mask = 10'h03f;
      3'd5:    div_mask = 10'h07f;
      3'd6:    div_mask = 10'h0ff;
      3'd7:    div_mask = 10'h3ff;
      default: div_mask = 10'h000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= t2ac_pkg::PRESC_RST;
    end else if (async_prescaler_reset) begin
      // counting resumes on the first tick after the bit drops
      presc <= t2ac_pkg::PRESC_RST;
    end else if (timer_tick) begin
      presc <= presc + 10'h001;
    end
  end

  assign count_en = timer_tick && !async_prescaler_reset &&
                    (live[t2ac_pkg::ENT_CTRL_B][2:0] != 3'd0) &&
                    ((presc & div_mask) == div_mask);

  // ---------------- counter core ----------------
  // wave mode: control B bit3 above control A bits 1:0
  assign wgm = {live[t2ac_pkg::ENT_CTRL_B][t2ac_pkg::BIT_WGM2],
                live[t2ac_pkg::ENT_CTRL_A][1:0]};
  assign phase_correct = (wgm[1:0] == 2'b01);
  // top comes from compare A in clear-on-match and the bit2 modes
  assign top = (wgm[2] || wgm[1:0] == 2'b10) ? live[t2ac_pkg::ENT_CMP_A]
                                             : t2ac_pkg::COUNT_MAX;

  always_comb begin
    // dual slope flags overflow at the bottom turn, never at top
    ev_ovf = 1'b0;
    if (count_en) begin
      if (phase_correct) begin
        ev_ovf = count_down &&
                 (live[t2ac_pkg::ENT_COUNTER] == t2ac_pkg::COUNT_BOT);
      end else if (wgm[1:0] == 2'b11) begin
        ev_ovf = (live[t2ac_pkg::ENT_COUNTER] == top);
      end else begin
        ev_ovf = (live[t2ac_pkg::ENT_COUNTER] == t2ac_pkg::COUNT_MAX);
      end
    end
  end

  // matches need a counting tick, so a stopped counter stays silent
  assign ev_cmp_a = count_en &&
    (live[t2ac_pkg::ENT_COUNTER] == live[t2ac_pkg::ENT_CMP_A]);
  assign ev_cmp_b = count_en &&
    (live[t2ac_pkg::ENT_COUNTER] == live[t2ac_pkg::ENT_CMP_B]);

  // a sync counter write, or a staged transfer in async mode, wins over counting in the same tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live[t2ac_pkg::ENT_COUNTER] <= t2ac_pkg::RST_BYTE;
      count_down <= 1'b0;
    end else if (wr_sel[t2ac_pkg::ENT_COUNTER] && !async_clock_select) begin
      live[t2ac_pkg::ENT_COUNTER] <= pwdata[7:0];
    end else if (busy[t2ac_pkg::ENT_COUNTER] && timer_tick &&
                 !wr_sel[t2ac_pkg::ENT_COUNTER]) begin
      live[t2ac_pkg::ENT_COUNTER] <= stage[t2ac_pkg::ENT_COUNTER];
    end else if (count_en) begin
      if (phase_correct) begin
        if (!count_down && live[t2ac_pkg::ENT_COUNTER] >= top) begin
          // turn at top; the top value itself is shown once
          count_down <= 1'b1;
          live[t2ac_pkg::ENT_COUNTER] <=
            live[t2ac_pkg::ENT_COUNTER] - 8'h01;
        end else if (count_down &&
                     live[t2ac_pkg::ENT_COUNTER] == t2ac_pkg::COUNT_BOT) begin
          count_down <= 1'b0;
          live[t2ac_pkg::ENT_COUNTER] <= 8'h01;
        end else if (count_down) begin
          live[t2ac_pkg::ENT_COUNTER] <=
            live[t2ac_pkg::ENT_COUNTER] - 8'h01;
        end else begin
          live[t2ac_pkg::ENT_COUNTER] <=
            live[t2ac_pkg::ENT_COUNTER] + 8'h01;
        end
      end else if (wgm[1:0] != 2'b00 &&
                   live[t2ac_pkg::ENT_COUNTER] == top) begin
        live[t2ac_pkg::ENT_COUNTER] <= t2ac_pkg::COUNT_BOT;
      end else begin
        live[t2ac_pkg::ENT_COUNTER] <= live[t2ac_pkg::ENT_COUNTER] + 8'h01;
      end
    end
  end

  // ---------------- interrupt mask and flags ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer2_interrupt_mask <= 3'b000;
    end else if (wr && idx == t2ac_pkg::IDX_MASK) begin
      // only the three event enables are stored
      timer2_interrupt_mask <= pwdata[2:0];
    end
  end

  always_comb begin
    events = 3'b000;
    events[t2ac_pkg::BIT_OVF]   = ev_ovf;
    events[t2ac_pkg::BIT_CMP_A] = ev_cmp_a;
    events[t2ac_pkg::BIT_CMP_B] = ev_cmp_b;
  end

  // set beats any clear landing in the same cycle
  for (genvar f = 0; f < t2ac_pkg::IRQ_BITS; f++) begin : g_flag
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        timer2_interrupt_flags[f] <= 1'b0;
      end else if (events[f]) begin
        timer2_interrupt_flags[f] <= 1'b1;
      end else if (vector_ack[f] ||
                   (wr && idx == t2ac_pkg::IDX_FLAGS && pwdata[f])) begin
        timer2_interrupt_flags[f] <= 1'b0;
      end
    end
    assign irq_req[f] = timer2_interrupt_mask[f] && global_irq_enable &&
                        timer2_interrupt_flags[f];
  end

  // summary line ignores the global enable; the requests honour it
  assign irq = |(timer2_interrupt_flags & timer2_interrupt_mask);

  // ---------------- general control ----------------
  // sync mode freezes both reset bits so the timers start together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_mode_hold         <= 1'b0;
      async_prescaler_reset  <= 1'b0;
      shared_prescaler_reset <= 1'b0;
    end else if (wr && idx == t2ac_pkg::IDX_GENERAL) begin
      sync_mode_hold <= pwdata[t2ac_pkg::BIT_SYNC_MODE];
      // leaving sync mode drops both bits at the same edge
      if (sync_mode_hold && !pwdata[t2ac_pkg::BIT_SYNC_MODE]) begin
        async_prescaler_reset  <= 1'b0;
        shared_prescaler_reset <= 1'b0;
      end else begin
        async_prescaler_reset  <= pwdata[t2ac_pkg::BIT_ASYNC_PRST];
        shared_prescaler_reset <= pwdata[t2ac_pkg::BIT_SHARED_PRST];
      end
    end else if (!sync_mode_hold) begin
      // outside sync mode a written shared bit lasts one cycle
      shared_prescaler_reset <= 1'b0;
      // async mode keeps the bit until a tick has reset the prescaler
      if (!async_clock_select || timer_tick) begin
        async_prescaler_reset <= 1'b0;
      end
    end
  end
endmodule

// >>> sim/t2ac_checker.sv
// port assertions for the timer2 register-side block
`timescale 1ns/10ps
module t2ac_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic              pclk,                  // clock
  input wire logic              presetn,               // reset, low
  input wire logic              psel,                  // select
  input wire logic              penable,               // enable
  input wire logic              pwrite,                // direction
  input wire logic [ADDR_W-1:0] paddr,                 // address
  input wire logic [31:0]       pwdata,                // write data
  input wire logic [31:0]       prdata,                // read data
  input wire logic              pready,                // ready
  input wire logic              pslverr,               // error
  input wire logic              tosc_in,               // oscillator
  input wire logic              global_irq_enable,     // i-bit
  input wire logic [2:0]        vector_ack,            // vector taken
  input wire logic [2:0]        irq_req,               // requests
  input wire logic              irq,                   // summary
  input wire logic              shared_prescaler_reset // other timers
);
  logic gen_wr;
  logic tsm_seen;
  assign gen_wr = psel && penable && pwrite && paddr == ADDR_W'(12'h10c);
  // last sync mode value written, tracked from the bus alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsm_seen <= 1'b0;
    end else if (gen_wr) begin
      tsm_seen <= pwdata[7];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  irq_b_gate_a: assert property (
    irq_req[2] |-> global_irq_enable && irq)
    else $error("compare b request without its cause");
  irq_a_gate_a: assert property (
    irq_req[1] |-> global_irq_enable && irq)
    else $error("compare a request without its cause");
  irq_ovf_gate_a: assert property (
    irq_req[0] |-> global_irq_enable && irq)
    else $error("overflow request without its cause");
  irq_global_a: assert property (
    !global_irq_enable |-> irq_req == 3'b000)
    else $error("request while global enable low");
  bus_ready_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  misalign_err_a: assert property (
    psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  upper_zero_a: assert property (prdata[31:8] == '0)
    else $error("read data upper bits not zero");
  sync_hold_a: assert property (
    gen_wr && pwdata[7] && pwdata[0] |=> shared_prescaler_reset [*2])
    else $error("reset bit not held in sync mode");
  sync_release_a: assert property (
    gen_wr && !pwdata[7] |=> ##1 !shared_prescaler_reset)
    else $error("reset bit not cleared");
  shared_set_a: assert property (
    gen_wr && pwdata[0] && (pwdata[7] || !tsm_seen)
    |=> shared_prescaler_reset)
    else $error("reset bit not taken");
  sync_exit_a: assert property (
    gen_wr && tsm_seen && !pwdata[7] |=> !shared_prescaler_reset)
    else $error("reset bit kept after sync mode exit");
endmodule
bind t2ac_timer t2ac_checker #(.ADDR_W(ADDR_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tosc_in(tosc_in),
  .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
  .irq_req(irq_req), .irq(irq),
  .shared_prescaler_reset(shared_prescaler_reset)
);

// >>> sim/t2ac_timer_tb.sv
// self-checking bench for the timer2 register-side block
`timescale 1ns/10ps
module t2ac_timer_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        tosc_in;
  logic        gie;
  logic [2:0]  vector_ack;
  logic [2:0]  irq_req;
  logic        irq;
  logic        shared_rst;
  int          n_fail;
  int          checks_done;
  int          k;

  t2ac_timer dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tosc_in(tosc_in),
    .global_irq_enable(gie), .vector_ack(vector_ack),
    .irq_req(irq_req), .irq(irq), .shared_prescaler_reset(shared_rst)
  );

  always #12.5 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // setup cycle, then hold until ready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, ad(i), d);
  endtask

  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    apb(1'b0, ad(i), 8'h00);
    chk(rd, {24'h0, e});
  endtask

  task automatic ack(input logic [2:0] v);
    vector_ack <= v;
    @(posedge pclk);
    vector_ack <= 3'b000;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    conclude();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    tosc_in = 1'b0;
    gie = 1'b0;
    vector_ack = 3'b000;
    n_fail = 0;
    checks_done = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc(t2ac_pkg::IDX_GENERAL, 8'h00);
    rdc(t2ac_pkg::IDX_ASYNC, 8'h00);
    rdc(t2ac_pkg::IDX_MASK, 8'h00);
    rdc(t2ac_pkg::IDX_FLAGS, 8'h00);
    apb(1'b0, 12'h140, 8'h00);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h11d, 8'h07);
    chk({31'h0, err}, 32'h1);
    rdc(t2ac_pkg::IDX_MASK, 8'h00);
    // counter stopped, so reads are exact
    wr(t2ac_pkg::IDX_COUNTER, 8'h5a);
    rdc(t2ac_pkg::IDX_COUNTER, 8'h5a);
    wr(t2ac_pkg::IDX_CMP_A, 8'hf8);
    wr(t2ac_pkg::IDX_CMP_B, 8'hfc);
    rdc(t2ac_pkg::IDX_CMP_A, 8'hf8);
    wr(t2ac_pkg::IDX_MASK, 8'h07);
    gie <= 1'b1;
    wr(t2ac_pkg::IDX_COUNTER, 8'hf0);
    wr(t2ac_pkg::IDX_CTRL_B, 8'h01);
    k = 0;
    do begin
      apb(1'b0, ad(t2ac_pkg::IDX_FLAGS), 8'h00);
      k++;
    end while (rd[2:0] !== 3'b111 && k < 100);
    wr(t2ac_pkg::IDX_CTRL_B, 8'h00);
    chk(rd, 32'h7);
    chk({29'h0, irq_req}, 32'h7);
    gie <= 1'b0;
    @(posedge pclk);
    chk({29'h0, irq_req}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    gie <= 1'b1;
    wr(t2ac_pkg::IDX_FLAGS, 8'h02);
    rdc(t2ac_pkg::IDX_FLAGS, 8'h05);
    ack(3'b100);
    rdc(t2ac_pkg::IDX_FLAGS, 8'h01);
    wr(t2ac_pkg::IDX_MASK, 8'h06);
    @(posedge pclk);
    chk({29'h0, irq_req}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    ack(3'b001);
    rdc(t2ac_pkg::IDX_FLAGS, 8'h00);
    // dual slope with top from compare A never reaches max
    wr(t2ac_pkg::IDX_CMP_A, 8'h04);
    wr(t2ac_pkg::IDX_COUNTER, 8'h00);
    wr(t2ac_pkg::IDX_CTRL_A, 8'h01);
    wr(t2ac_pkg::IDX_CTRL_B, 8'h09);
    k = 0;
    do begin
      apb(1'b0, ad(t2ac_pkg::IDX_FLAGS), 8'h00);
      k++;
    end while (rd[0] !== 1'b1 && k < 100);
    wr(t2ac_pkg::IDX_CTRL_B, 8'h00);
    chk({31'h0, rd[0]}, 32'h1);
    wr(t2ac_pkg::IDX_FLAGS, 8'h07);
    rdc(t2ac_pkg::IDX_FLAGS, 8'h00);
    wr(t2ac_pkg::IDX_GENERAL, 8'h83);
    rdc(t2ac_pkg::IDX_GENERAL, 8'h83);
    chk({31'h0, shared_rst}, 32'h1);
    wr(t2ac_pkg::IDX_GENERAL, 8'h00);
    rdc(t2ac_pkg::IDX_GENERAL, 8'h00);
    wr(t2ac_pkg::IDX_GENERAL, 8'h01);
    rdc(t2ac_pkg::IDX_GENERAL, 8'h00);
    wr(t2ac_pkg::IDX_GENERAL, 8'h02);
    rdc(t2ac_pkg::IDX_GENERAL, 8'h00);
    // oscillator held still, so staged writes wait for one tick
    wr(t2ac_pkg::IDX_ASYNC, 8'h20);
    rdc(t2ac_pkg::IDX_ASYNC, 8'h20);
    wr(t2ac_pkg::IDX_CTRL_A, 8'h03);
    wr(t2ac_pkg::IDX_CTRL_B, 8'h08);
    wr(t2ac_pkg::IDX_CMP_B, 8'h11);
    wr(t2ac_pkg::IDX_CMP_A, 8'h22);
    wr(t2ac_pkg::IDX_COUNTER, 8'h44);
    rdc(t2ac_pkg::IDX_ASYNC, 8'h3f);
    rdc(t2ac_pkg::IDX_CTRL_A, 8'h03);
    wr(t2ac_pkg::IDX_GENERAL, 8'h02);
    rdc(t2ac_pkg::IDX_GENERAL, 8'h02);
    tosc_in <= 1'b1;
    repeat (8) @(posedge pclk);
    tosc_in <= 1'b0;
    rdc(t2ac_pkg::IDX_ASYNC, 8'h20);
    rdc(t2ac_pkg::IDX_GENERAL, 8'h00);
    rdc(t2ac_pkg::IDX_COUNTER, 8'h44);
    rdc(t2ac_pkg::IDX_CMP_B, 8'h11);
    wr(t2ac_pkg::IDX_CMP_B, 8'h33);
    rdc(t2ac_pkg::IDX_ASYNC, 8'h24);
    rdc(t2ac_pkg::IDX_CMP_B, 8'h33);
    conclude();
  end
endmodule
